// File: standby_seq_map.svh
// register offsets, field positions, reset values and counts of the standby sequencer
`ifndef STANDBY_SEQ_MAP_SVH
`define STANDBY_SEQ_MAP_SVH

`define SSQ_OFF_CTRL 8'h00
`define SSQ_OFF_PROG 8'h04
`define SSQ_OFF_GEN 8'h08
`define SSQ_OFF_MODE 8'h0C
`define SSQ_OFF_MASK 8'h10
`define SSQ_OFF_STAT 8'h14
`define SSQ_OFF_ISTAT 8'h18
`define SSQ_OFF_ICLR 8'h1C
`define SSQ_OFF_IEN 8'h20

`define SSQ_CTRL_START 0
`define SSQ_CTRL_TSEL_LO 1
`define SSQ_CTRL_TSEL_HI 2
`define SSQ_CTRL_WAKE 3
`define SSQ_CTRL_FSTOP 4
`define SSQ_CTRL_RST 5'h00

`define SSQ_PROG_STEPS_RST 8'h04
`define SSQ_PROG_BASE_RST 16'h0000
`define SSQ_MASK_RST 1'b1

`define SSQ_IRQ_DONE 0
`define SSQ_IRQ_FSTOP 1
`define SSQ_IRQ_REFUSED 2
`define SSQ_IRQ_BLOCKED 3
`define SSQ_IRQ_W 4

`define SSQ_RESTRICT_BASE 16'hF000
`define SSQ_RESP_OKAY 2'b00
`define SSQ_RESP_SLVERR 2'b10

`endif

// File: standby_seq_pkg.sv
// types shared by the standby sequencer modules
package standby_seq_pkg;
	typedef enum logic [1:0] {PM_RUN = 2'b00, PM_HALT = 2'b01, PM_STOP = 2'b10,
		PM_SNOOZE = 2'b11} pmode_t;
	typedef enum logic [1:0] {SQ_STOPPED = 2'b00, SQ_WAIT = 2'b01, SQ_RUN = 2'b10}
		seq_state_t;
	typedef enum logic [1:0] {CS_HIGH = 2'b00, CS_MID = 2'b01, CS_LOW = 2'b10,
		CS_SUB = 2'b11} clk_src_t;
	typedef enum logic [1:0] {TS_NONE = 2'b00, TS_SERIAL = 2'b01, TS_UART = 2'b10,
		TS_ADC = 2'b11} trig_sel_t;
endpackage

// File: seq_if.sv
// link between the power controller and the sequencer engine
`timescale 1ns/1ps
`default_nettype none
interface seq_if;
	logic start_en;
	logic force_stop;
	logic wake_cmd;
	logic run_ok;
	logic trig;
	logic [7:0] steps;
	standby_seq_pkg::seq_state_t state;
	logic done;
	logic done_irq;
	logic mem_req;
	logic [7:0] mem_idx;
	modport eng(input start_en, force_stop, wake_cmd, run_ok, trig, steps,
		output state, done, done_irq, mem_req, mem_idx);
	modport ctl(output start_en, force_stop, wake_cmd, run_ok, trig, steps,
		input state, done, done_irq, mem_req, mem_idx);
endinterface
`default_nettype wire

// File: seq_engine.sv
// sequencer engine: waits for a trigger, runs a round of steps, ends
`timescale 1ns/1ps
`default_nettype none
module seq_engine (
	input wire logic aclk,
	input wire logic aresetn,
	seq_if.eng sif
);
	standby_seq_pkg::seq_state_t state_ff;
	logic [7:0] step_ff;
	logic done_ff;
	logic done_irq_ff;
	logic last_step;

	// a zero step count still runs one step
	assign last_step = ({1'b0, step_ff} + 9'h001) >= {1'b0, sif.steps};

	// round control; forced stop beats everything
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_ff <= standby_seq_pkg::SQ_STOPPED;
		end else if (sif.force_stop) begin
			state_ff <= standby_seq_pkg::SQ_STOPPED;
		end else begin
			case (state_ff)
				standby_seq_pkg::SQ_STOPPED: begin
					if (sif.start_en) state_ff <= standby_seq_pkg::SQ_WAIT;
				end
				standby_seq_pkg::SQ_WAIT: begin
					if (!sif.start_en) state_ff <= standby_seq_pkg::SQ_STOPPED;
					else if (sif.trig) state_ff <= standby_seq_pkg::SQ_RUN;
				end
				standby_seq_pkg::SQ_RUN: begin
					if (sif.run_ok && last_step) state_ff <= standby_seq_pkg::SQ_WAIT;
				end
				default: state_ff <= standby_seq_pkg::SQ_STOPPED;
			endcase
		end
	end

	// step counter only moves while the power mode lets it
	always_ff @(posedge aclk) begin
		if (!aresetn || state_ff != standby_seq_pkg::SQ_RUN) begin
			step_ff <= 8'h00;
		end else if (sif.run_ok && !last_step) begin
			step_ff <= step_ff + 8'h01;
		end
	end

	// end-of-round pulses
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			done_ff <= 1'b0;
			done_irq_ff <= 1'b0;
		end else begin
			done_ff <= state_ff == standby_seq_pkg::SQ_RUN && sif.run_ok && last_step
				&& !sif.force_stop;
			done_irq_ff <= state_ff == standby_seq_pkg::SQ_RUN && sif.run_ok && last_step
				&& !sif.force_stop && sif.wake_cmd;
		end
	end

	assign sif.state = state_ff;
	assign sif.done = done_ff;
	assign sif.done_irq = done_irq_ff;
	assign sif.mem_req = state_ff == standby_seq_pkg::SQ_RUN && sif.run_ok;
	assign sif.mem_idx = step_ff;

	property p_round_end;
		@(posedge aclk) disable iff (!aresetn)
		(state_ff == standby_seq_pkg::SQ_RUN && sif.run_ok && last_step && !sif.force_stop)
			|=> (state_ff == standby_seq_pkg::SQ_WAIT && done_ff);
	endproperty
	a_round_end: assert property (p_round_end) else $error("round did not end in wait");
endmodule
`default_nettype wire

// File: standby_seq_ctrl.sv
// standby sequencer power-mode controller with register slave
`include "standby_seq_map.svh"
`timescale 1ns/1ps
`default_nettype none
module standby_seq_ctrl #(
	parameter int AW = 16,
	parameter logic [15:0] RESTRICT_BASE = `SSQ_RESTRICT_BASE
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic cpu_halt_req,
	input wire logic cpu_stop_req,
	input wire logic wake_req,
	input wire logic [1:0] clk_src,
	input wire logic trig_serial,
	input wire logic trig_uart,
	input wire logic trig_adc,
	output logic seq_mem_req,
	output logic [15:0] seq_mem_addr,
	output logic seq_mem_grant,
	output logic [1:0] power_mode,
	output logic cpu_clk_en,
	output logic seq_end_interrupt,
	output logic irq
);
	seq_if sif();

	standby_seq_pkg::pmode_t pm_ff;
	logic [4:0] ctrl_ff;
	logic [7:0] steps_ff;
	logic [15:0] base_ff;
	logic [31:0] gen_ff;
	logic rtc_low_power_select_ff;
	logic seq_end_irq_mask_ff;
	logic [`SSQ_IRQ_W-1:0] istat_ff;
	logic [`SSQ_IRQ_W-1:0] ien_ff;
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	logic rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0] rresp_ff;
	logic seq_end_ff;
	logic wr_go;
	logic rd_go;
	logic force_stop_wr;
	logic snooze_ok;
	logic sub_low_power;
	logic wake_unmasked;
	logic mem_blocked;
	logic refused;
	logic [`SSQ_IRQ_W-1:0] iclr;
	logic [`SSQ_IRQ_W-1:0] iset;

	seq_engine u_engine (
		.aclk(aclk),
		.aresetn(aresetn),
		.sif(sif)
	);

	// write takes address and data together; one response outstanding at most
	assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_ff;
	assign rd_go = s_axi_arvalid && !rvalid_ff;
	assign s_axi_awready = wr_go;
	assign s_axi_wready = wr_go;
	assign s_axi_arready = rd_go;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;

	// mode conditions
	assign snooze_ok = clk_src == standby_seq_pkg::CS_HIGH || clk_src == standby_seq_pkg::CS_MID;
	assign sub_low_power = clk_src == standby_seq_pkg::CS_SUB && rtc_low_power_select_ff;
	assign wake_unmasked = sif.done_irq && !seq_end_irq_mask_ff;
	assign force_stop_wr = wr_go && s_axi_awaddr == `SSQ_OFF_CTRL && s_axi_wstrb[0]
		&& s_axi_wdata[`SSQ_CTRL_FSTOP];

	// engine steering
	assign sif.start_en = ctrl_ff[`SSQ_CTRL_START];
	assign sif.wake_cmd = ctrl_ff[`SSQ_CTRL_WAKE];
	assign sif.force_stop = force_stop_wr;
	assign sif.steps = steps_ff;
	assign sif.run_ok = pm_ff == standby_seq_pkg::PM_RUN || pm_ff == standby_seq_pkg::PM_SNOOZE
		|| (pm_ff == standby_seq_pkg::PM_HALT && !sub_low_power);
	// trigger select picks one peripheral event; accepted in any power mode
	always_comb begin
		case (ctrl_ff[`SSQ_CTRL_TSEL_HI:`SSQ_CTRL_TSEL_LO])
			standby_seq_pkg::TS_SERIAL: sif.trig = trig_serial;
			standby_seq_pkg::TS_UART: sif.trig = trig_uart;
			standby_seq_pkg::TS_ADC: sif.trig = trig_adc;
			default: sif.trig = 1'b0;
		endcase
	end

	// memory port; restricted region refused while snoozing
	assign seq_mem_req = sif.mem_req;
	assign seq_mem_addr = base_ff + {8'h00, sif.mem_idx};
	assign mem_blocked = sif.mem_req && pm_ff == standby_seq_pkg::PM_SNOOZE
		&& seq_mem_addr >= RESTRICT_BASE;
	assign seq_mem_grant = sif.mem_req && !mem_blocked;

	// a busy round in STOP with a wrong clock cannot snooze
	assign refused = pm_ff == standby_seq_pkg::PM_STOP && sif.state == standby_seq_pkg::SQ_RUN
		&& !snooze_ok;

	// power mode sequencing
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pm_ff <= standby_seq_pkg::PM_RUN;
		end else begin
			case (pm_ff)
				standby_seq_pkg::PM_RUN: begin
					if (cpu_stop_req) pm_ff <= standby_seq_pkg::PM_STOP;
					else if (cpu_halt_req) pm_ff <= standby_seq_pkg::PM_HALT;
				end
				standby_seq_pkg::PM_HALT: begin
					if (wake_req || wake_unmasked) pm_ff <= standby_seq_pkg::PM_RUN;
				end
				standby_seq_pkg::PM_STOP: begin
					if (wake_req) pm_ff <= standby_seq_pkg::PM_RUN;
					else if (sif.state == standby_seq_pkg::SQ_RUN && snooze_ok)
						pm_ff <= standby_seq_pkg::PM_SNOOZE;
				end
				standby_seq_pkg::PM_SNOOZE: begin
					if (wake_req || wake_unmasked) pm_ff <= standby_seq_pkg::PM_RUN;
					else if (sif.done || force_stop_wr)
						pm_ff <= standby_seq_pkg::PM_STOP;
				end
				default: pm_ff <= standby_seq_pkg::PM_RUN;
			endcase
		end
	end

	assign power_mode = pm_ff;
	assign cpu_clk_en = pm_ff == standby_seq_pkg::PM_RUN;

	// end interrupt to the interrupt controller, one cycle per wake-up round
	always_ff @(posedge aclk) begin
		if (!aresetn) seq_end_ff <= 1'b0;
		else seq_end_ff <= sif.done_irq;
	end
	assign seq_end_interrupt = seq_end_ff;

	// control register; forced stop wipes it, other registers untouched except its ISTAT flag
	always_ff @(posedge aclk) begin
		if (!aresetn || force_stop_wr) begin
			ctrl_ff <= `SSQ_CTRL_RST;
		end else if (wr_go && s_axi_awaddr == `SSQ_OFF_CTRL && s_axi_wstrb[0]) begin
			ctrl_ff <= {1'b0, s_axi_wdata[3:0]};
		end
	end

	// program, general, mode, mask and interrupt-enable registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			steps_ff <= `SSQ_PROG_STEPS_RST;
			base_ff <= `SSQ_PROG_BASE_RST;
			gen_ff <= 32'h0000_0000;
			rtc_low_power_select_ff <= 1'b0;
			seq_end_irq_mask_ff <= `SSQ_MASK_RST;
			ien_ff <= '0;
		end else if (wr_go) begin
			case (s_axi_awaddr)
				`SSQ_OFF_PROG: begin
					if (s_axi_wstrb[0]) steps_ff <= s_axi_wdata[7:0];
					if (s_axi_wstrb[2]) base_ff[7:0] <= s_axi_wdata[23:16];
					if (s_axi_wstrb[3]) base_ff[15:8] <= s_axi_wdata[31:24];
				end
				`SSQ_OFF_GEN: begin
					for (int i = 0; i < 4; i++) begin
						if (s_axi_wstrb[i]) gen_ff[i*8 +: 8] <= s_axi_wdata[i*8 +: 8];
					end
				end
				`SSQ_OFF_MODE: begin
					if (s_axi_wstrb[0]) rtc_low_power_select_ff <= s_axi_wdata[0];
				end
				`SSQ_OFF_MASK: begin
					if (s_axi_wstrb[0]) seq_end_irq_mask_ff <= s_axi_wdata[0];
				end
				`SSQ_OFF_IEN: begin
					if (s_axi_wstrb[0]) ien_ff <= s_axi_wdata[`SSQ_IRQ_W-1:0];
				end
				default: begin
				end
			endcase
		end
	end

	// sticky event flags; a set in the clearing cycle survives
	assign iclr = (wr_go && s_axi_awaddr == `SSQ_OFF_ICLR && s_axi_wstrb[0])
		? s_axi_wdata[`SSQ_IRQ_W-1:0] : '0;
	assign iset = {mem_blocked, refused, force_stop_wr, sif.done};
	always_ff @(posedge aclk) begin
		if (!aresetn) istat_ff <= '0;
		else istat_ff <= (istat_ff & ~iclr) | iset;
	end
	assign irq = |(istat_ff & ien_ff);

	// write response; unmapped offsets answer with an error
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= `SSQ_RESP_OKAY;
		end else if (wr_go) begin
			bvalid_ff <= 1'b1;
			case (s_axi_awaddr)
				`SSQ_OFF_CTRL, `SSQ_OFF_PROG, `SSQ_OFF_GEN, `SSQ_OFF_MODE, `SSQ_OFF_MASK,
				`SSQ_OFF_STAT, `SSQ_OFF_ISTAT, `SSQ_OFF_ICLR, `SSQ_OFF_IEN:
					bresp_ff <= `SSQ_RESP_OKAY;
				default: bresp_ff <= `SSQ_RESP_SLVERR;
			endcase
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	// read data; write-only and reserved bits read zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			rresp_ff <= `SSQ_RESP_OKAY;
		end else if (rd_go) begin
			rvalid_ff <= 1'b1;
			rresp_ff <= `SSQ_RESP_OKAY;
			case (s_axi_araddr)
				`SSQ_OFF_CTRL: rdata_ff <= {28'h0000000, ctrl_ff[3:0]};
				`SSQ_OFF_PROG: rdata_ff <= {base_ff, 8'h00, steps_ff};
				`SSQ_OFF_GEN: rdata_ff <= gen_ff;
				`SSQ_OFF_MODE: rdata_ff <= {31'h00000000, rtc_low_power_select_ff};
				`SSQ_OFF_MASK: rdata_ff <= {31'h00000000, seq_end_irq_mask_ff};
				`SSQ_OFF_STAT: rdata_ff <= {26'h0000000, clk_src, sif.state, pm_ff};
				`SSQ_OFF_ISTAT: rdata_ff <= {28'h0000000, istat_ff};
				`SSQ_OFF_ICLR: rdata_ff <= 32'h0000_0000;
				`SSQ_OFF_IEN: rdata_ff <= {28'h0000000, ien_ff};
				default: begin
					rdata_ff <= 32'h0000_0000;
					rresp_ff <= `SSQ_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	// the sequence itself must wake the CPU or rearm the masked trigger
	// source (serial, UART or converter) before ending; nothing checks it here

	sequence s_in_snooze;
		pm_ff == standby_seq_pkg::PM_SNOOZE;
	endsequence
	sequence s_wake_end;
		s_in_snooze ##0 (sif.done_irq && !seq_end_irq_mask_ff);
	endsequence

	property p_halt_frozen;
		@(posedge aclk) disable iff (!aresetn)
		(pm_ff == standby_seq_pkg::PM_HALT && sub_low_power && sif.state == standby_seq_pkg::SQ_RUN
			&& !force_stop_wr) |=> ($stable(sif.mem_idx) && !sif.done);
	endproperty
	a_halt_frozen: assert property (p_halt_frozen) else $error("sequencer ran in low-power halt");

	property p_stop_to_snooze;
		@(posedge aclk) disable iff (!aresetn)
		(pm_ff == standby_seq_pkg::PM_STOP && !wake_req && sif.state == standby_seq_pkg::SQ_RUN
			&& snooze_ok) |=> s_in_snooze;
	endproperty
	a_stop_to_snooze: assert property (p_stop_to_snooze) else $error("trigger in stop no snooze");

	property p_back_to_stop;
		@(posedge aclk) disable iff (!aresetn)
		(s_in_snooze ##0 (sif.done && !sif.done_irq && !wake_req))
			|=> pm_ff == standby_seq_pkg::PM_STOP;
	endproperty
	a_back_to_stop: assert property (p_back_to_stop) else $error("snooze did not return to stop");

	property p_snooze_clock;
		@(posedge aclk) disable iff (!aresetn)
		(pm_ff == standby_seq_pkg::PM_SNOOZE && $past(pm_ff) != standby_seq_pkg::PM_SNOOZE)
			|-> $past(snooze_ok);
	endproperty
	a_snooze_clock: assert property (p_snooze_clock) else $error("snooze with wrong clock");

	property p_mem_block;
		@(posedge aclk) disable iff (!aresetn)
		(s_in_snooze ##0 (seq_mem_req && seq_mem_addr >= RESTRICT_BASE)) |-> !seq_mem_grant
			##1 istat_ff[`SSQ_IRQ_BLOCKED];
	endproperty
	a_mem_block: assert property (p_mem_block) else $error("restricted access in snooze");

	property p_force_stop;
		@(posedge aclk) disable iff (!aresetn)
		force_stop_wr |=> (ctrl_ff == `SSQ_CTRL_RST && $stable(gen_ff) && $stable(steps_ff)
			&& sif.state == standby_seq_pkg::SQ_STOPPED);
	endproperty
	a_force_stop: assert property (p_force_stop) else $error("forced stop handling wrong");

	property p_snooze_wake;
		@(posedge aclk) disable iff (!aresetn)
		s_wake_end |=> (pm_ff == standby_seq_pkg::PM_RUN && cpu_clk_en && seq_end_interrupt)
			##1 pm_ff != standby_seq_pkg::PM_STOP;
	endproperty
	a_snooze_wake: assert property (p_snooze_wake) else $error("end interrupt did not wake");
endmodule
`default_nettype wire

// File: standby_host_model.sv
// behavioural model of cpu, interrupt controller and triggering peripherals
`timescale 1ns/1ps
`default_nettype none
module standby_host_model (
	input wire logic aclk,
	output logic cpu_halt_req,
	output logic cpu_stop_req,
	output logic wake_req,
	output logic [1:0] clk_src,
	output logic trig_serial,
	output logic trig_uart,
	output logic trig_adc
);
	// receivers are one-shot: after an end event they stay silent until re-armed
	logic [2:0] armed_ff;

	initial begin
		{wake_req, cpu_stop_req, cpu_halt_req} = 3'h0;
		{trig_adc, trig_uart, trig_serial} = 3'h0;
		clk_src = 2'h0;
		armed_ff = 3'h7;
	end

	// {wake, stop, halt} request held for one cycle
	task automatic cpu_req(input logic [2:0] r);
		@(posedge aclk);
		{wake_req, cpu_stop_req, cpu_halt_req} <= r;
		@(posedge aclk);
		{wake_req, cpu_stop_req, cpu_halt_req} <= 3'h0;
	endtask

	// {adc, uart, serial} end event, only from armed receivers
	task automatic peri_fire(input logic [2:0] t);
		@(posedge aclk);
		{trig_adc, trig_uart, trig_serial} <= t & armed_ff;
		armed_ff = armed_ff & ~t;
		@(posedge aclk);
		{trig_adc, trig_uart, trig_serial} <= 3'h0;
	endtask

	// sequence restarts reception or rewrites the wakeup conversion bit
	task automatic rearm(input logic [2:0] t);
		armed_ff = armed_ff | t;
	endtask

	// oscillator selection seen by the power controller
	task automatic set_clk(input logic [1:0] c);
		@(posedge aclk);
		clk_src <= c;
	endtask
endmodule
`default_nettype wire

// File: standby_sequencer_wakeup_tb_top.sv
// self-checking bench of the standby sequencer power-mode controller
`include "standby_seq_map.svh"
`timescale 1ns/1ps
`default_nettype none
module standby_sequencer_wakeup_tb_top;
	logic aclk, aresetn;
	logic [7:0] aw_a, ar_a;
	logic [31:0] w_d, r_d;
	logic aw_v, aw_r, w_v, w_r, b_v, b_r, ar_v, ar_r, r_v, r_r;
	logic [1:0] b_p, r_p, clk_src, power_mode;
	logic cpu_halt_req, cpu_stop_req, wake_req, trig_serial, trig_uart, trig_adc;
	logic seq_mem_req, seq_mem_grant, cpu_clk_en, seq_end_interrupt, irq;
	int miscompares, checks, cycles, end_cnt, n;
	logic [31:0] d;
	logic [1:0] r;
	logic [2:0] prot;
	logic [3:0] w_s;
	logic [15:0] mem_a;

	standby_seq_ctrl u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw_a),
		.s_axi_awprot(prot), .s_axi_awvalid(aw_v), .s_axi_awready(aw_r), .s_axi_wdata(w_d),
		.s_axi_wstrb(w_s), .s_axi_wvalid(w_v), .s_axi_wready(w_r), .s_axi_bresp(b_p),
		.s_axi_bvalid(b_v), .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arprot(prot),
		.s_axi_arvalid(ar_v), .s_axi_arready(ar_r), .s_axi_rdata(r_d), .s_axi_rresp(r_p),
		.s_axi_rvalid(r_v), .s_axi_rready(r_r), .cpu_halt_req(cpu_halt_req),
		.cpu_stop_req(cpu_stop_req), .wake_req(wake_req), .clk_src(clk_src),
		.trig_serial(trig_serial), .trig_uart(trig_uart), .trig_adc(trig_adc),
		.seq_mem_req(seq_mem_req), .seq_mem_addr(mem_a), .seq_mem_grant(seq_mem_grant),
		.power_mode(power_mode), .cpu_clk_en(cpu_clk_en),
		.seq_end_interrupt(seq_end_interrupt), .irq(irq));

	standby_host_model u_host (.aclk(aclk), .cpu_halt_req(cpu_halt_req),
		.cpu_stop_req(cpu_stop_req), .wake_req(wake_req), .clk_src(clk_src),
		.trig_serial(trig_serial), .trig_uart(trig_uart), .trig_adc(trig_adc));

	// 40 MHz clock
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	// hang guard well above the run length; end pulses counted for the wake case
	always @(posedge aclk) begin
		cycles++;
		if (seq_end_interrupt === 1'b1) end_cnt++;
		if (cycles == 20000) begin
			miscompares++;
			report_and_stop();
		end
	end

	task automatic report_and_stop;
		if (miscompares == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_pin(input logic [1:0] got, input logic [1:0] exp);
		chk_data({30'h0, got}, {30'h0, exp});
	endtask

	// write: address and data offered together, each released when taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] p);
		@(posedge aclk);
		aw_a <= a;
		w_d <= v;
		aw_v <= 1'b1;
		w_v <= 1'b1;
		b_r <= 1'b1;
		forever begin
			@(posedge aclk);
			if (aw_v && aw_r) aw_v <= 1'b0;
			if (w_v && w_r) w_v <= 1'b0;
			if (b_v === 1'b1) begin
				p = b_p;
				b_r <= 1'b0;
				break;
			end
		end
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] p);
		@(posedge aclk);
		ar_a <= a;
		ar_v <= 1'b1;
		r_r <= 1'b1;
		forever begin
			@(posedge aclk);
			if (ar_v && ar_r) ar_v <= 1'b0;
			if (r_v === 1'b1) begin
				v = r_d;
				p = r_p;
				r_r <= 1'b0;
				break;
			end
		end
	endtask

	task automatic wr_ok(input logic [7:0] a, input logic [31:0] v);
		logic [1:0] p;
		axi_wr(a, v, p);
		chk_pin(p, `SSQ_RESP_OKAY);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] v;
		logic [1:0] p;
		axi_rd(a, v, p);
		chk_pin(p, `SSQ_RESP_OKAY);
		chk_data(v, exp);
	endtask

	// bounded wait for a power mode, then compare it
	task automatic wait_mode(input logic [1:0] m);
		n = 0;
		while (power_mode !== m && n < 200) begin
			@(posedge aclk);
			n++;
		end
		chk_pin(power_mode, m);
	endtask

	initial begin
		miscompares = 0;
		checks = 0;
		cycles = 0;
		end_cnt = 0;
		aresetn = 1'b0;
		{aw_v, w_v, b_r, ar_v, r_r} = 5'h00;
		aw_a = 8'h00;
		ar_a = 8'h00;
		w_d = 32'h0;
		prot = 3'h0;
		w_s = 4'hF;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		// reset values and an unmapped offset
		rd_chk(`SSQ_OFF_CTRL, 32'h0);
		rd_chk(`SSQ_OFF_PROG, 32'h4);
		rd_chk(`SSQ_OFF_MASK, 32'h1);
		axi_rd(8'h40, d, r);
		chk_pin(r, `SSQ_RESP_SLVERR);
		chk_data(d, 32'h0);
		axi_wr(8'h40, 32'hFFFF_FFFF, r);
		chk_pin(r, `SSQ_RESP_SLVERR);
		wr_ok(`SSQ_OFF_IEN, 32'h1);
		// serial trigger in STOP, program in restricted space
		wr_ok(`SSQ_OFF_PROG, 32'hF000_0002);
		wr_ok(`SSQ_OFF_CTRL, 32'h3);
		u_host.cpu_req(3'h2);
		wait_mode(2'h2);
		u_host.peri_fire(3'h1);
		wait_mode(2'h3);
		chk_pin({seq_mem_req, seq_mem_grant}, 2'h2);
		chk_data({16'h0000, mem_a}, 32'h0000_F000);
		wait_mode(2'h2);
		rd_chk(`SSQ_OFF_ISTAT, 32'h9);
		rd_chk(`SSQ_OFF_STAT, 32'h6);
		chk_pin({1'b0, irq}, 2'h1);
		u_host.cpu_req(3'h4);
		wait_mode(2'h0);
		wr_ok(`SSQ_OFF_ICLR, 32'hF);
		rd_chk(`SSQ_OFF_ISTAT, 32'h0);
		chk_pin({1'b0, irq}, 2'h0);
		// uart trigger, unmasked end interrupt wakes the cpu
		u_host.rearm(3'h1);
		wr_ok(`SSQ_OFF_PROG, 32'h3);
		wr_ok(`SSQ_OFF_MASK, 32'h0);
		wr_ok(`SSQ_OFF_CTRL, 32'hD);
		u_host.cpu_req(3'h2);
		wait_mode(2'h2);
		u_host.peri_fire(3'h2);
		wait_mode(2'h3);
		chk_pin({seq_mem_req, seq_mem_grant}, 2'h3);
		chk_data({16'h0000, mem_a}, 32'h0000_0000);
		wait_mode(2'h0);
		repeat (3) @(posedge aclk);
		chk_pin({1'b0, cpu_clk_en}, 2'h1);
		chk_data(end_cnt, 32'h1);
		wr_ok(`SSQ_OFF_ICLR, 32'hF);
		// low oscillator: no snooze, refusal flagged, masked from irq first
		u_host.set_clk(2'h2);
		wr_ok(`SSQ_OFF_CTRL, 32'h7);
		u_host.cpu_req(3'h2);
		wait_mode(2'h2);
		u_host.peri_fire(3'h4);
		repeat (6) @(posedge aclk);
		chk_pin(power_mode, 2'h2);
		axi_rd(`SSQ_OFF_ISTAT, d, r);
		chk_data(d & 32'h4, 32'h4);
		chk_pin({1'b0, irq}, 2'h0);
		wr_ok(`SSQ_OFF_IEN, 32'h5);
		repeat (2) @(posedge aclk);
		chk_pin({1'b0, irq}, 2'h1);
		u_host.cpu_req(3'h4);
		wait_mode(2'h0);
		// forced stop clears control only
		wr_ok(`SSQ_OFF_GEN, 32'hA5A5_5A5A);
		wr_ok(`SSQ_OFF_CTRL, 32'h10);
		rd_chk(`SSQ_OFF_CTRL, 32'h0);
		rd_chk(`SSQ_OFF_GEN, 32'hA5A5_5A5A);
		// only the strobed low half of the scratch word may change
		w_s <= 4'h3;
		wr_ok(`SSQ_OFF_GEN, 32'h1234_5678);
		w_s <= 4'hF;
		rd_chk(`SSQ_OFF_GEN, 32'hA5A5_5678);
		rd_chk(`SSQ_OFF_PROG, 32'h3);
		rd_chk(`SSQ_OFF_STAT, 32'h20);
		wr_ok(`SSQ_OFF_IEN, 32'h1);
		wr_ok(`SSQ_OFF_ICLR, 32'hF);
		// halt on subclock with low-power rtc select stalls the round
		u_host.rearm(3'h1);
		u_host.set_clk(2'h3);
		wr_ok(`SSQ_OFF_MODE, 32'h1);
		wr_ok(`SSQ_OFF_CTRL, 32'h3);
		u_host.cpu_req(3'h1);
		wait_mode(2'h1);
		u_host.peri_fire(3'h1);
		repeat (6) @(posedge aclk);
		chk_pin({1'b0, seq_mem_req}, 2'h0);
		axi_rd(`SSQ_OFF_ISTAT, d, r);
		chk_data(d & 32'h1, 32'h0);
		wr_ok(`SSQ_OFF_MODE, 32'h0);
		repeat (6) @(posedge aclk);
		axi_rd(`SSQ_OFF_ISTAT, d, r);
		chk_data(d & 32'h1, 32'h1);
		u_host.cpu_req(3'h4);
		wait_mode(2'h0);
		report_and_stop();
	end
endmodule
`default_nettype wire
